//--- logic/sss_serial_slave.sv
// Purpose: Two-wire slave front end with watchdog and low-supply reset control
// Assumes: clk_link_i oversamples the bus lines; clk_sys_i is the device timebase
// Notes:   Bus lines pass two flops on clk_link_i; supply flags two on clk_sys_i
// Overview of operation
// - Select bits choose watchdog timeout or off
// - Every start reloads full watchdog period
// - Expired watchdog drives reset one timeout
// - Start during reset timeout has no effect
// - Battery mode disables the watchdog
// - Low supply holds reset; release 250ms later
// - Running nonvolatile write completes under low supply
// - Low supply aborts transactions, rejects commands; code does neither in battery mode
// - Battery mode after a low-supply dip holds reset until main supply
// - Data changes only while clock low
// - Falling data, clock high, is start
// - Rising data, clock high, is stop
// - Receiver acknowledges each byte on ninth clock
// - Acknowledge address only after start and match
// - Write mode acknowledges every further byte
// - Read sends byte, continues only on acknowledge
// - Upper nibble selects array or control space
// - Select bits 111 fixed in address byte
// - Two-byte word address; counter clears to zero
`include "sss_params.svh"

module sss_serial_slave
    import sss_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic        clk_link_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        watchdog_period_sel_hi_i,
    input  wire logic        watchdog_period_sel_lo_i,
    input  wire logic        supply_low_i,
    input  wire logic        battery_mode_i,
    input  wire logic        nv_write_busy_i,
    input  wire logic [7:0]  rd_data_i,
    output logic [15:0]      word_addr_o,
    output logic             space_ctrl_o,
    output logic             wr_strobe_o,
    output logic [7:0]       wr_data_o,
    output logic             low_supply_supervisor_n_o,
    output logic             reset_n_o
);

    localparam logic [31:0] WD_250_CYC  = 32'(`SSS_MS_CYC(`SSS_WD_SHORT_MS));
    localparam logic [31:0] WD_750_CYC  = 32'(`SSS_MS_CYC(`SSS_WD_MID_MS));
    localparam logic [31:0] WD_1750_CYC = 32'(`SSS_MS_CYC(`SSS_WD_LONG_MS));
    localparam logic [31:0] RST_CYC     = 32'(`SSS_MS_CYC(`SSS_RST_TIMEOUT_MS));

    sss_pins_t pins_ff;
    sss_pins_t nxt_pins;
    sss_link_t lnk_ff;
    sss_link_t nxt_lnk;
    sss_sys_t  sys_ff;
    sss_sys_t  nxt_sys;
    logic      lowv_sup_n_ff;

    logic scl_s;
    logic sda_s;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic [1:0]  wd_sel;
    logic [31:0] wd_reload;

    assign scl_s     = pins_ff.scl_sync[1];
    assign sda_s     = pins_ff.sda_sync[1];
    assign start_det = scl_s && pins_ff.scl_prev && pins_ff.sda_prev && !sda_s;
    assign stop_det  = scl_s && pins_ff.scl_prev && !pins_ff.sda_prev && sda_s;
    assign scl_rise  = scl_s && !pins_ff.scl_prev;
    assign scl_fall  = !scl_s && pins_ff.scl_prev;

    // Link side: pin synchronisers
    always_comb
    begin
        nxt_pins          = pins_ff;
        nxt_pins.scl_sync = {pins_ff.scl_sync[0], scl_i};
        nxt_pins.sda_sync = {pins_ff.sda_sync[0], sda_i};
        nxt_pins.scl_prev = scl_s;
        nxt_pins.sda_prev = sda_s;
    end

    // Link side: byte engine
    always_comb
    begin
        nxt_lnk            = lnk_ff;
        nxt_lnk.wr_pulse   = 1'b0;
        nxt_lnk.abort_sync = {lnk_ff.abort_sync[0], sys_ff.abort};
        if (lnk_ff.abort_sync[1])
        begin
            nxt_lnk.state  = SSS_IDLE;
            nxt_lnk.sda_oe = 1'b0;
        end
        else if (start_det)
        begin
            nxt_lnk.start_tog = !lnk_ff.start_tog;
            nxt_lnk.state     = SSS_DEVAD;
            nxt_lnk.bit_cnt   = 4'h0;
            nxt_lnk.ack_phase = 1'b0;
            nxt_lnk.sda_oe    = 1'b0;
        end
        else if (stop_det)
        begin
            nxt_lnk.state  = SSS_IDLE;
            nxt_lnk.sda_oe = 1'b0;
        end
        else if (lnk_ff.state != SSS_IDLE && lnk_ff.state != SSS_IGNORE)
        begin
            // Shifting on rising SCL, driving on falling SCL keeps SDA stable while SCL is high
            if (scl_rise && !lnk_ff.ack_phase)
            begin
                nxt_lnk.shift   = {lnk_ff.shift[6:0], sda_s};
                nxt_lnk.bit_cnt = lnk_ff.bit_cnt + 4'h1;
            end
            if (scl_rise && lnk_ff.ack_phase && lnk_ff.state == SSS_RDATA && sda_s)
                nxt_lnk.state = SSS_IGNORE;
            if (scl_fall)
            begin
                if (lnk_ff.ack_phase)
                begin
                    nxt_lnk.ack_phase = 1'b0;
                    nxt_lnk.bit_cnt   = 4'h0;
                    nxt_lnk.sda_oe    = 1'b0;
                    if (lnk_ff.state == SSS_RDATA)
                    begin
                        nxt_lnk.shift  = rd_data_i;
                        nxt_lnk.sda_oe = !rd_data_i[7];
                    end
                end
                else if (lnk_ff.bit_cnt == 4'h8)
                begin
                    nxt_lnk.ack_phase = 1'b1;
                    nxt_lnk.sda_oe    = 1'b0;
                    case (lnk_ff.state)
                        SSS_DEVAD:
                        begin
                            if ((lnk_ff.shift[7:4] == `SSS_ID_ARRAY
                                 || lnk_ff.shift[7:4] == `SSS_ID_CTRL)
                                && lnk_ff.shift[3:1] == `SSS_SEL_BITS
                                && !(nv_write_busy_i && lnk_ff.shift[7:4] == `SSS_ID_ARRAY))
                            begin
                                nxt_lnk.sda_oe     = 1'b1;
                                nxt_lnk.space_ctrl = lnk_ff.shift[7:4] == `SSS_ID_CTRL;
                                nxt_lnk.rd_mode    = lnk_ff.shift[0];
                                nxt_lnk.state      = lnk_ff.shift[0] ? SSS_RDATA : SSS_WADDR;
                                nxt_lnk.addr_hi_done = 1'b0;
                            end
                            else
                            begin
                                nxt_lnk.state = SSS_IGNORE;
                            end
                        end
                        SSS_WADDR:
                        begin
                            nxt_lnk.sda_oe = 1'b1;
                            if (!lnk_ff.addr_hi_done)
                            begin
                                nxt_lnk.word_addr[15:8] = lnk_ff.shift;
                                nxt_lnk.addr_hi_done    = 1'b1;
                            end
                            else
                            begin
                                nxt_lnk.word_addr[7:0] = lnk_ff.shift;
                                nxt_lnk.state          = SSS_WDATA;
                            end
                        end
                        SSS_WDATA:
                        begin
                            nxt_lnk.sda_oe    = 1'b1;
                            nxt_lnk.wr_data   = lnk_ff.shift;
                            nxt_lnk.wr_pulse  = 1'b1;
                            nxt_lnk.word_addr = lnk_ff.word_addr + 16'h0001;
                        end
                        SSS_RDATA:
                        begin
                            nxt_lnk.word_addr = lnk_ff.word_addr + 16'h0001;
                        end
                        default:
                        begin
                            nxt_lnk.state = SSS_IGNORE;
                        end
                    endcase
                end
                else if (lnk_ff.state == SSS_RDATA)
                begin
                    // The shift register has already moved the next bit into the MSB
                    nxt_lnk.sda_oe = !lnk_ff.shift[7];
                end
            end
        end
        if (lnk_ff.state == SSS_RDATA && lnk_ff.bit_cnt == 4'h0 && !lnk_ff.ack_phase
            && scl_fall && !nxt_lnk.sda_oe && lnk_ff.sda_oe)
            nxt_lnk.sda_oe = lnk_ff.sda_oe;
    end

    always_ff @(posedge clk_link_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pins_ff <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1};
            lnk_ff  <= '{state: SSS_IDLE, word_addr: `SSS_ADDR_RESET, default: '0};
        end
        else
        begin
            pins_ff <= nxt_pins;
            lnk_ff  <= nxt_lnk;
        end
    end

    // System side: watchdog and supply reset
    always_comb
    begin
        wd_sel = {watchdog_period_sel_hi_i, watchdog_period_sel_lo_i};
        case (wd_sel)
            `SSS_WD_250: wd_reload = WD_250_CYC;
            `SSS_WD_750: wd_reload = WD_750_CYC;
            `SSS_WD_1750: wd_reload = WD_1750_CYC;
            default:     wd_reload = 32'h00000000;
        endcase
    end

    always_comb
    begin
        nxt_sys            = sys_ff;
        nxt_sys.lowv_sync  = {sys_ff.lowv_sync[0], supply_low_i};
        nxt_sys.batt_sync  = {sys_ff.batt_sync[0], battery_mode_i};
        nxt_sys.start_sync = {sys_ff.start_sync[1:0], lnk_ff.start_tog};
        // Battery mode after a dip keeps reset until main supply returns
        if (sys_ff.batt_sync[1] && sys_ff.lowv_sync[1])
            nxt_sys.lowv_seen_batt = 1'b1;
        else if (!sys_ff.batt_sync[1])
            nxt_sys.lowv_seen_batt = 1'b0;
        if (sys_ff.lowv_sync[1] || sys_ff.lowv_seen_batt)
        begin
            nxt_sys.rst_cnt    = RST_CYC;
            nxt_sys.wd_rst_run = 1'b0;
            nxt_sys.wd_cnt     = wd_reload;
        end
        else if (sys_ff.rst_cnt != 32'h00000000)
        begin
            nxt_sys.rst_cnt = sys_ff.rst_cnt - 32'h00000001;
            if (sys_ff.rst_cnt == 32'h00000001)
            begin
                nxt_sys.wd_rst_run = 1'b0;
                nxt_sys.wd_cnt     = wd_reload;
            end
        end
        else if (wd_sel == `SSS_WD_OFF || sys_ff.batt_sync[1])
        begin
            nxt_sys.wd_cnt = wd_reload;
        end
        else if (sys_ff.start_sync[2] != sys_ff.start_sync[1])
        begin
            nxt_sys.wd_cnt = wd_reload;
        end
        else if (sys_ff.wd_cnt <= 32'h00000001)
        begin
            nxt_sys.wd_rst_run = 1'b1;
            nxt_sys.rst_cnt    = RST_CYC;
        end
        else
        begin
            nxt_sys.wd_cnt = sys_ff.wd_cnt - 32'h00000001;
        end
        nxt_sys.rst_n = !(sys_ff.lowv_sync[1] || sys_ff.lowv_seen_batt
                          || sys_ff.rst_cnt != 32'h00000000);
        // Abort only hits the bus; the nonvolatile write runs on outside
        nxt_sys.abort = sys_ff.lowv_sync[1] && !sys_ff.batt_sync[1];
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sys_ff        <= '{rst_cnt: RST_CYC, default: '0};
            lowv_sup_n_ff <= 1'b1;
        end
        else
        begin
            sys_ff        <= nxt_sys;
            lowv_sup_n_ff <= !sys_ff.lowv_sync[1];
        end
    end

    assign sda_o                     = 1'b0;
    assign sda_oe_o                  = lnk_ff.sda_oe;
    assign word_addr_o               = lnk_ff.word_addr;
    assign space_ctrl_o              = lnk_ff.space_ctrl;
    assign wr_strobe_o               = lnk_ff.wr_pulse;
    assign wr_data_o                 = lnk_ff.wr_data;
    assign low_supply_supervisor_n_o = lowv_sup_n_ff;
    assign reset_n_o                 = sys_ff.rst_n;

endmodule

//--- include/sss_params.svh
// Purpose: Constants for the two-wire slave and supervisor block
// Assumes: System clock of 40 MHz
// Notes:   Times are kept in their printed units; counts derive from them
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH

`define SSS_CLK_HZ          40000000
`define SSS_WD_SHORT_MS     250
`define SSS_WD_MID_MS       750
`define SSS_WD_LONG_MS      1750
`define SSS_RST_TIMEOUT_MS  250
`define SSS_MS_CYC(ms)      (((ms) * (`SSS_CLK_HZ / 1000)))
`define SSS_ID_ARRAY        4'hA
`define SSS_ID_CTRL         4'hD
`define SSS_SEL_BITS        3'h7
`define SSS_WD_OFF          2'h3
`define SSS_WD_250          2'h2
`define SSS_WD_750          2'h1
`define SSS_WD_1750         2'h0
`define SSS_ADDR_RESET      16'h0000

`endif

//--- include/sss_pkg.sv
// Purpose: Types for the two-wire slave and supervisor block
// Assumes: Constants come from sss_params.svh
// Notes:   Link-side and system-side state are kept apart
package sss_pkg;

    typedef enum logic [2:0] {
        SSS_IDLE  = 3'b000,
        SSS_DEVAD = 3'b001,
        SSS_WADDR = 3'b010,
        SSS_WDATA = 3'b011,
        SSS_RDATA = 3'b100,
        SSS_IGNORE = 3'b101
    } sss_bus_st_t;

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic       scl_prev;
        logic       sda_prev;
    } sss_pins_t;

    typedef struct packed {
        sss_bus_st_t state;
        logic [3:0]  bit_cnt;
        logic [7:0]  shift;
        logic        ack_phase;
        logic        space_ctrl;
        logic        addr_hi_done;
        logic [15:0] word_addr;
        logic        sda_oe;
        logic        start_tog;
        logic        wr_pulse;
        logic [7:0]  wr_data;
        logic        byte_valid;
        logic        rd_mode;
        logic [1:0]  abort_sync;
    } sss_link_t;

    typedef struct packed {
        logic [1:0]  lowv_sync;
        logic [1:0]  batt_sync;
        logic [2:0]  start_sync;
        logic [31:0] wd_cnt;
        logic [31:0] rst_cnt;
        logic        wd_rst_run;
        logic        lowv_seen_batt;
        logic        rst_n;
        logic        abort;
    } sss_sys_t;

endpackage

//--- dv/sss_serial_slave_sva.sv
// Purpose: Port checks for the two-wire slave and supervisor
// Assumes: Inputs mirror ports of sss_serial_slave
// Notes:   Bound at the foot of this file
module sss_serial_slave_sva
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic clk_link_i,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic supply_low_i,
    input wire logic battery_mode_i,
    input wire logic wr_strobe_o,
    input wire logic low_supply_supervisor_n_o,
    input wire logic reset_n_o
);
    sequence s_low_held;
        (supply_low_i && !battery_mode_i)[*8];
    endsequence
    sequence s_batt_dip;
        (battery_mode_i && supply_low_i)[*4] ##1 battery_mode_i[*4];
    endsequence

    a_sda_open_drain: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        sda_oe_o |-> sda_o == 1'b0) else $error("sda driven high");
    a_oe_scl_low: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        $changed(sda_oe_o) |-> !scl_i) else $error("sda drive moved with scl high");
    a_strobe_single: assert property (@(posedge clk_link_i) disable iff (!nrst_i)
        wr_strobe_o |=> !wr_strobe_o) else $error("write strobe longer than one cycle");
    a_reset_low_sup: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        supply_low_i[*4] |=> !reset_n_o) else $error("reset not low on low supply");
    a_flag_low_sup: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        supply_low_i[*4] |=> !low_supply_supervisor_n_o) else $error("low supply flag high");
    a_abort_low_sup: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_low_held |-> !sda_oe_o) else $error("bus answered under low supply");
    a_batt_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_batt_dip |-> !reset_n_o) else $error("reset released in battery mode");
    a_por_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> !reset_n_o[*8]) else $error("reset released too early");
endmodule

bind sss_serial_slave sss_serial_slave_sva u_sss_serial_slave_sva
(
    .clk_sys_i                (clk_sys_i),
    .nrst_i                   (nrst_i),
    .clk_link_i               (clk_link_i),
    .scl_i                    (scl_i),
    .sda_o                    (sda_o),
    .sda_oe_o                 (sda_oe_o),
    .supply_low_i             (supply_low_i),
    .battery_mode_i           (battery_mode_i),
    .wr_strobe_o              (wr_strobe_o),
    .low_supply_supervisor_n_o(low_supply_supervisor_n_o),
    .reset_n_o                (reset_n_o)
);

//--- dv/sss_bus_master.sv
// Purpose: Behavioural two-wire bus master
// Assumes: Quarter bit time above six link clocks
// Notes:   SDA is released high by a pull-up; SCL is driven both ways
module sss_bus_master
(
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int Q = 40;
    initial
    begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic start;
        sda_pull_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_pull_o = 1'b1;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    task automatic stop;
        sda_pull_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_pull_o = 1'b0;
        #Q;
    endtask
    // Sends tx (FF releases the line) and drives ack_in on the ninth clock
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        logic [8:0] sh;
        sh = {tx, !ack_in};
        for (int i = 8; i >= 0; i--)
        begin
            sda_pull_o = !sh[i];
            #Q scl_o = 1'b1;
            #Q sh[i] = sda_i;
            #Q scl_o = 1'b0;
            #Q;
        end
        rx = sh[8:1];
        ack = !sh[0];
    endtask
endmodule

//--- dv/tb_sss_serial_slave.sv
// Purpose: Self-checking bench for the two-wire slave
// Assumes: Master model drives scl and pulls sda
// Notes:   Watchdog periods are far beyond the run length
module tb_sss_serial_slave;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i, nrst_i, clk_link_i, supply_low_i, battery_mode_i, nv_busy, ack;
    logic [1:0] wd_sel;
    logic scl_w, sda_pull, sda_o, sda_oe_o, space_ctrl_o, wr_strobe_o, lvs_n, reset_n_o;
    logic [15:0] word_addr_o;
    logic [7:0] wr_data_o, rx;
    wire sda_w = !(sda_pull || sda_oe_o);
    wire [7:0] rd_data = word_addr_o[7:0] ^ 8'hC3;
    int n_errors = 0, n_checks = 0, n_cyc = 0, n_strobe = 0;

    sss_serial_slave u_sss_serial_slave (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .clk_link_i(clk_link_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .watchdog_period_sel_hi_i(wd_sel[1]),
        .watchdog_period_sel_lo_i(wd_sel[0]), .supply_low_i(supply_low_i),
        .battery_mode_i(battery_mode_i), .nv_write_busy_i(nv_busy), .rd_data_i(rd_data),
        .word_addr_o(word_addr_o), .space_ctrl_o(space_ctrl_o), .wr_strobe_o(wr_strobe_o),
        .wr_data_o(wr_data_o), .low_supply_supervisor_n_o(lvs_n), .reset_n_o(reset_n_o));
    sss_bus_master u_sss_bus_master (.sda_i(sda_w), .scl_o(scl_w), .sda_pull_o(sda_pull));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = !clk_sys_i;
    end
    initial
    begin
        clk_link_i = 1'b0;
        #1.7;
        forever #3 clk_link_i = !clk_link_i;
    end
    always @(posedge clk_link_i)
        if (wr_strobe_o === 1'b1)
            n_strobe <= n_strobe + 1;
    always @(posedge clk_sys_i)
    begin
        n_cyc++;
        if (n_cyc == 20000)
        begin
            n_errors++;
            close_out();
        end
    end

    task automatic tick;
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic probe(logic [7:0] a, logic exp);
        u_sss_bus_master.start();
        u_sss_bus_master.xfer(a, 1'b0, rx, ack);
        chk("address ack", {15'h0, exp}, {15'h0, ack});
        if (exp)
            chk("space select", {15'h0, a[6]}, {15'h0, space_ctrl_o});
        u_sss_bus_master.stop();
    endtask
    task automatic t_addr;
        logic [7:0] tbl [6] = '{8'hAE, 8'hDE, 8'hBE, 8'hAC, 8'h5E, 8'hDA};
        for (int i = 0; i < 6; i++)
        begin
            tick();
            wd_sel = i[1:0];
            probe(tbl[i], i < 2);
        end
        $display("test address done");
    endtask
    task automatic t_write;
        logic [7:0] b [4] = '{8'hAE, 8'h12, 8'h34, 8'h5A};
        n_strobe = 0;
        u_sss_bus_master.start();
        for (int i = 0; i < 4; i++)
        begin
            u_sss_bus_master.xfer(b[i], 1'b0, rx, ack);
            chk("write ack", 16'h0001, {15'h0, ack});
        end
        chk("write data", 16'h005A, {8'h0, wr_data_o});
        chk("strobes", 16'h0001, 16'(n_strobe));
        chk("word address", 16'h1235, word_addr_o);
        u_sss_bus_master.stop();
        $display("test write done");
    endtask
    task automatic t_read;
        logic [7:0] b [3] = '{8'hAE, 8'h00, 8'h10};
        u_sss_bus_master.start();
        for (int i = 0; i < 3; i++)
            u_sss_bus_master.xfer(b[i], 1'b0, rx, ack);
        u_sss_bus_master.start();
        u_sss_bus_master.xfer(8'hAF, 1'b0, rx, ack);
        chk("read ack", 16'h0001, {15'h0, ack});
        u_sss_bus_master.xfer(8'hFF, 1'b1, rx, ack);
        chk("read byte 0", 16'h00D3, {8'h0, rx});
        u_sss_bus_master.xfer(8'hFF, 1'b0, rx, ack);
        chk("read byte 1", 16'h00D2, {8'h0, rx});
        u_sss_bus_master.stop();
        chk("released", 16'h0000, {15'h0, sda_oe_o});
        $display("test read done");
    endtask
    task automatic t_lowv;
        tick();
        nv_busy = 1'b1;
        probe(8'hAE, 1'b0);
        probe(8'hDE, 1'b1);
        tick();
        nv_busy = 1'b0;
        supply_low_i = 1'b1;
        repeat (10) tick();
        chk("low flag", 16'h0000, {15'h0, lvs_n});
        chk("reset low", 16'h0000, {15'h0, reset_n_o});
        probe(8'hDE, 1'b0);
        battery_mode_i = 1'b1;
        repeat (10) tick();
        supply_low_i = 1'b0;
        repeat (10) tick();
        chk("battery reset", 16'h0000, {15'h0, reset_n_o});
        battery_mode_i = 1'b0;
        repeat (10) tick();
        chk("low flag off", 16'h0001, {15'h0, lvs_n});
        $display("test low supply done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        nrst_i = 1'b0;
        supply_low_i = 1'b0;
        battery_mode_i = 1'b0;
        nv_busy = 1'b0;
        wd_sel = 2'h3;
        repeat (8) tick();
        nrst_i = 1'b1;
        repeat (4) tick();
        chk("word address", 16'h0000, word_addr_o);
        chk("reset low", 16'h0000, {15'h0, reset_n_o});
        chk("low flag idle", 16'h0001, {15'h0, lvs_n});
        t_addr();
        t_write();
        t_read();
        t_lowv();
        close_out();
    end
endmodule
